// file: verilog/swic_regs.svh
// Constants for the switch interface control block: command word fields and reset values.
`ifndef SWIC_REGS_SVH
`define SWIC_REGS_SVH
`define SWIC_BIT_WD_DISABLE   0
`define SWIC_BIT_SLOPE_IRQ    1
`define SWIC_BIT_INT_CTRL     2
`define SWIC_BIT_SINK_SEL     3
`define SWIC_BIT_SRC_ENABLE   4
`define SWIC_ADDR_LSB         5
`define SWIC_ADDR_MSB         7
`define SWIC_BIT_PROG_ENABLE  8
`define SWIC_BIT_CUR_MULT     9
`define SWIC_BIT_MON_ENABLE   10
`define SWIC_MON_SEL_LSB      11
`define SWIC_MON_SEL_MSB      14
`define SWIC_BIT_MON_LOAD     15
`define SWIC_SINK_PORTS       3
`define SWIC_RST_CFG          8'h00
`define SWIC_RST_STATUS       16'h0000
`endif

// file: verilog/swic_pkg.sv
// Types shared by the switch interface control block.
package swic_pkg;
  typedef enum logic [1:0] {
    SWIC_IDLE,
    SWIC_SHIFT,
    SWIC_DONE
  } swic_spi_state_t;
endpackage : swic_pkg

// file: verilog/swic_ctrl.sv
// Switch interface control: SPI command decode, per-port source control, comparator sampling and interrupt.
//
// What this block does
// - With programming enable set, bit 1 is the addressed port's interrupt enable.
// - With programming enable clear, bit 1 sets the common slope control disable.
// - Source enable bit turns the addressed port's current source on or off.
// - Internal control bit picks modulation input or source enable as port control.
// - Sink/source select changes sink or source mode; only ports 1 to 3 obey it.
// - One common slope disable bit acts on all eight sources; zero means gradual.
// - Port configuration changes only when addressed and programming enable is one.
// - Current multiplier setting halves source current versus the default setting.
// - With source enable set, internal control clear and modulation input high turns the source on.
// - Comparator is sampled on each falling edge of the port's control signal.
// - Enabled port whose sampled state changes drives the interrupt pin low.
// - Interrupt pin stays low until the next SPI command completes.
// - Status flags track comparator changes; returned word refreshes after a command.
// - Monitor output selects battery sense or one of the eight switch ports.
`timescale 1ns/100ps
`include "swic_regs.svh"

module swic_ctrl
  import swic_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int WORD_W = 16
) (
  input  wire logic              CORE_CLK_I,        // Core clock, 200 MHz.
  input  wire logic              RESETN_I,          // Synchronous reset, active low.
  input  wire logic              SPI_SCK_I,         // SPI clock from the master, sampled.
  input  wire logic              SPI_CS_N_I,        // SPI chip select, active low.
  input  wire logic              SPI_MOSI_I,        // SPI data in, MSB first.
  output logic                   SPI_MISO_O,        // SPI data out, status word MSB first.
  input  wire logic [2:0]        MOD_IN_I,          // Modulation inputs one to three.
  input  wire logic [NPORTS-1:0] COMP_I,            // High-voltage comparator outputs.
  output logic [NPORTS-1:0]      SRC_ON_O,          // Current source on per port.
  output logic [NPORTS-1:0]      SINK_MODE_O,       // Low-side sink mode per port.
  output logic                   SLOPE_DISABLE_O,   // Common slope control disable.
  output logic                   CUR_HALF_O,        // Source current halved.
  output logic                   MON_ENABLE_O,      // Voltage monitor enabled.
  output logic [3:0]             MON_SEL_O,         // Monitor source: 0 battery, 1..8 ports.
  output logic                   WD_DISABLE_O,      // Watchdog disable bit as written.
  output logic                   IRQ_N_O            // Interrupt output, active low.
);

  // Two-stage synchronisers for every pin from outside this clock domain.
  logic [2:0]        sck_sync_ff, cs_sync_ff, mosi_sync_ff;
  logic [2:0]        mod_s1_ff, mod_s2_ff;
  logic [NPORTS-1:0] comp_s1_ff, comp_s2_ff;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      sck_sync_ff  <= 3'h0;
      cs_sync_ff   <= 3'h7;
      mosi_sync_ff <= 3'h0;
      mod_s1_ff    <= 3'h0;
      mod_s2_ff    <= 3'h0;
      comp_s1_ff   <= '0;
      comp_s2_ff   <= '0;
    end else begin
      sck_sync_ff  <= {sck_sync_ff[1:0], SPI_SCK_I};
      cs_sync_ff   <= {cs_sync_ff[1:0], SPI_CS_N_I};
      mosi_sync_ff <= {mosi_sync_ff[1:0], SPI_MOSI_I};
      mod_s1_ff    <= MOD_IN_I;
      mod_s2_ff    <= mod_s1_ff;
      comp_s1_ff   <= COMP_I;
      comp_s2_ff   <= comp_s1_ff;
    end
  end

  // Edge detection reads only the second and third stages, never the first.
  logic sck_rise, sck_fall, cs_act, cs_start, cs_end;
  assign sck_rise = sck_sync_ff[1] & ~sck_sync_ff[2];
  assign sck_fall = ~sck_sync_ff[1] & sck_sync_ff[2];
  assign cs_act   = ~cs_sync_ff[1];
  assign cs_start = ~cs_sync_ff[1] & cs_sync_ff[2];
  assign cs_end   = cs_sync_ff[1] & ~cs_sync_ff[2];

  // SPI slave: shift in on rising SCK, shift out on falling SCK, commit when CS rises after 16 bits.
  swic_spi_state_t   state_ff;
  logic [WORD_W-1:0] rx_ff, tx_ff, status_ff;
  logic [4:0]        bit_cnt_ff;
  logic              cmd_done;
  assign cmd_done = (state_ff == SWIC_SHIFT) && cs_end && (bit_cnt_ff == 5'(WORD_W));

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      state_ff   <= SWIC_IDLE;
      rx_ff      <= '0;
      tx_ff      <= '0;
      bit_cnt_ff <= 5'h00;
    end else begin
      case (state_ff)
        SWIC_IDLE: begin
          if (cs_start) begin
            state_ff   <= SWIC_SHIFT;
            bit_cnt_ff <= 5'h00;
            tx_ff      <= status_ff;  // Word returned is the one latched at the last command end.
          end
        end
        SWIC_SHIFT: begin
          if (!cs_act) begin
            state_ff <= SWIC_DONE;
          end else if (sck_rise) begin
            rx_ff      <= {rx_ff[WORD_W-2:0], mosi_sync_ff[1]};
            bit_cnt_ff <= (bit_cnt_ff == 5'(WORD_W)) ? bit_cnt_ff : bit_cnt_ff + 5'h01;
          end else if (sck_fall) begin
            tx_ff <= {tx_ff[WORD_W-2:0], 1'b0};
          end
        end
        SWIC_DONE: state_ff <= SWIC_IDLE;
        default:   state_ff <= SWIC_IDLE;
      endcase
    end
  end
  assign SPI_MISO_O = tx_ff[WORD_W-1];

  // Command decode; a word with a short bit count is ignored as a whole.
  logic [2:0] addr;
  logic       prog_en;
  assign addr    = rx_ff[`SWIC_ADDR_MSB:`SWIC_ADDR_LSB];
  assign prog_en = rx_ff[`SWIC_BIT_PROG_ENABLE];

  // Per-port configuration, changed only by an addressed word with programming enable.
  logic [NPORTS-1:0] src_en_ff, int_ctl_ff, sink_ff, irq_en_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      src_en_ff  <= `SWIC_RST_CFG;
      int_ctl_ff <= `SWIC_RST_CFG;
      sink_ff    <= `SWIC_RST_CFG;
      irq_en_ff  <= `SWIC_RST_CFG;
    end else if (cmd_done && prog_en) begin
      src_en_ff[addr]  <= rx_ff[`SWIC_BIT_SRC_ENABLE];
      int_ctl_ff[addr] <= rx_ff[`SWIC_BIT_INT_CTRL];
      irq_en_ff[addr]  <= rx_ff[`SWIC_BIT_SLOPE_IRQ];
      // Only the first three ports have a sink stage.
      sink_ff[addr] <= (int'(addr) < `SWIC_SINK_PORTS) ? rx_ff[`SWIC_BIT_SINK_SEL] : 1'b0;
    end
  end

  // Common settings from every completed word; slope disable only without programming enable, monitor only with bit 15.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      SLOPE_DISABLE_O <= 1'b0;
      CUR_HALF_O      <= 1'b0;
      MON_ENABLE_O    <= 1'b0;
      MON_SEL_O       <= 4'h0;
      WD_DISABLE_O    <= 1'b0;
    end else if (cmd_done) begin
      if (!prog_en) begin
        SLOPE_DISABLE_O <= rx_ff[`SWIC_BIT_SLOPE_IRQ];
      end
      CUR_HALF_O   <= rx_ff[`SWIC_BIT_CUR_MULT];
      WD_DISABLE_O <= rx_ff[`SWIC_BIT_WD_DISABLE];
      if (rx_ff[`SWIC_BIT_MON_LOAD]) begin
        MON_ENABLE_O <= rx_ff[`SWIC_BIT_MON_ENABLE];
        // Out-of-range selections fall back to battery sense.
        MON_SEL_O <= (rx_ff[`SWIC_MON_SEL_MSB:`SWIC_MON_SEL_LSB] > 4'h8) ? 4'h0
                     : rx_ff[`SWIC_MON_SEL_MSB:`SWIC_MON_SEL_LSB];
      end
    end
  end

  // Control signal per port: fixed map of modulation inputs, or the source enable bit.
  logic [NPORTS-1:0] mod_map;
  assign mod_map = {mod_s2_ff[0], mod_s2_ff[0], mod_s2_ff[1], mod_s2_ff[1],
                    mod_s2_ff[2], mod_s2_ff[2], mod_s2_ff[1], mod_s2_ff[0]};
  logic [NPORTS-1:0] drive;
  always_comb begin
    for (int i = 0; i < NPORTS; i++) begin
      drive[i] = src_en_ff[i] & (int_ctl_ff[i] | mod_map[i]);
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      SRC_ON_O    <= '0;
      SINK_MODE_O <= '0;
    end else begin
      SRC_ON_O    <= drive;
      SINK_MODE_O <= sink_ff;
    end
  end

  // Sample comparators on each falling edge of the per-port control signal.
  logic [NPORTS-1:0] drive_d_ff, sample_ff;
  logic [NPORTS-1:0] fall_ev, change_ev;
  assign fall_ev   = drive_d_ff & ~drive;
  assign change_ev = fall_ev & (comp_s2_ff ^ sample_ff);

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      drive_d_ff <= '0;
      sample_ff  <= '0;
    end else begin
      drive_d_ff <= drive;
      for (int i = 0; i < NPORTS; i++) begin
        if (fall_ev[i]) begin
          sample_ff[i] <= comp_s2_ff[i];
        end
      end
    end
  end

  // Interrupt latch: a new change wins over the clear at command end.
  logic irq_ff;
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      irq_ff <= 1'b0;
    end else if (|(change_ev & irq_en_ff)) begin
      irq_ff <= 1'b1;
    end else if (cmd_done) begin
      irq_ff <= 1'b0;
    end
  end
  assign IRQ_N_O = ~irq_ff;

  // Switch state flags follow sampled state; the returned word refreshes only at command end.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      status_ff <= `SWIC_RST_STATUS;
    end else if (cmd_done) begin
      status_ff <= {7'h00, irq_ff, sample_ff};
    end
  end

  // Checks.
  a_cfg_needs_prog: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    !(cmd_done && prog_en) |=> $stable(src_en_ff) && $stable(irq_en_ff))
    else $error("Port configuration changed without programming enable.");
  a_irq_raise: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    |(change_ev & irq_en_ff) |=> !IRQ_N_O)
    else $error("Enabled comparator change did not raise interrupt.");
  a_irq_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (!IRQ_N_O && !cmd_done) |=> !IRQ_N_O)
    else $error("Interrupt released before command end.");
  a_no_sink_high: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    SINK_MODE_O[NPORTS-1:3] == '0)
    else $error("Sink mode on a port without sink stage.");
  a_status_stable: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    !cmd_done |=> $stable(status_ff))
    else $error("Status word changed outside command end.");
  a_slope_common: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (cmd_done && !prog_en) |=> SLOPE_DISABLE_O == $past(rx_ff[1]))
    else $error("Slope disable not taken from bit 1.");
  a_mod_drive: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    (src_en_ff[0] && !int_ctl_ff[0] && mod_s2_ff[0]) |=> SRC_ON_O[0])
    else $error("Modulation input high did not turn source on.");
  a_sample_edge: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    fall_ev[0] |=> sample_ff[0] == $past(comp_s2_ff[0]))
    else $error("Comparator not sampled on falling control edge.");
  a_mon_range: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    MON_SEL_O <= 4'h8)
    else $error("Monitor selection out of range.");
  a_cur_half: assert property (@(posedge CORE_CLK_I) disable iff (!RESETN_I)
    cmd_done |=> CUR_HALF_O == $past(rx_ff[9]))
    else $error("Current multiplier not taken.");
  c_prog_word: cover property (@(posedge CORE_CLK_I) disable iff (!RESETN_I) cmd_done && prog_en);
  c_irq: cover property (@(posedge CORE_CLK_I) disable iff (!RESETN_I) $fell(IRQ_N_O));
  c_irq_clear: cover property (@(posedge CORE_CLK_I) disable iff (!RESETN_I) $rose(IRQ_N_O));
  c_sample: cover property (@(posedge CORE_CLK_I) disable iff (!RESETN_I) |change_ev);

endmodule : swic_ctrl

// file: verification/swic_spi_master.sv
// SPI master model standing in for the microcontroller that configures the block.
`timescale 1ns/100ps
module swic_spi_master (
  input  wire logic clk_i,   // Core clock, used for bit timing.
  input  wire logic miso_i,  // Status data from the device.
  output logic      sck_o,   // SPI clock, still and low outside frames.
  output logic      cs_n_o,  // Chip select, active low.
  output logic      mosi_o   // Command data, MSB first.
);
  // Idle levels at time zero.
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Sends nbits of a word; ten core cycles a phase keeps SCK well under the sync limit.
  task automatic xfer(input logic [15:0] cmd, input int nbits, output logic [15:0] rsp);
    rsp = 16'h0000;
    @(negedge clk_i) cs_n_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = cmd[15-i];
      repeat (10) @(negedge clk_i);
      rsp = {rsp[14:0], miso_i};
      sck_o = 1'b1;
      repeat (10) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (10) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o; // A released line must not keep showing the last bit.
    repeat (12) @(negedge clk_i);
  endtask : xfer
endmodule : swic_spi_master

// file: verification/tb.sv
// Self-checking testbench for the switch interface control block.
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sck, cs_n, mosi, miso, slope, cur, mon_en, wd, irq_n;
  logic [2:0]  mod = 3'h0;
  logic [7:0]  comp = 8'h00;
  logic [7:0]  src, sink;
  logic [3:0]  mon_sel;
  logic [15:0] rsp;
  int          err_total = 0;
  int          tests_run = 0;
  // One row: command, modulation inputs, expected source and sink outputs.
  typedef struct {logic [15:0] cmd; logic [2:0] mod; logic [7:0] src; logic [7:0] sink;} swic_row_t;
  swic_row_t rows [6] = '{'{16'h0114, 3'h0, 8'h01, 8'h00}, '{16'h0138, 3'h2, 8'h03, 8'h02},
    '{16'h00F4, 3'h2, 8'h03, 8'h02}, '{16'h01FC, 3'h2, 8'h83, 8'h02},
    '{16'h0118, 3'h2, 8'h82, 8'h03}, '{16'h0118, 3'h1, 8'h81, 8'h03}};
  // Free-running 200 MHz core clock.
  always #2.5 clk = ~clk;
  swic_ctrl dut (.CORE_CLK_I(clk), .RESETN_I(rst_n), .SPI_SCK_I(sck), .SPI_CS_N_I(cs_n),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .MOD_IN_I(mod), .COMP_I(comp), .SRC_ON_O(src),
    .SINK_MODE_O(sink), .SLOPE_DISABLE_O(slope), .CUR_HALF_O(cur), .MON_ENABLE_O(mon_en),
    .MON_SEL_O(mon_sel), .WD_DISABLE_O(wd), .IRQ_N_O(irq_n));
  swic_spi_master mst (.clk_i(clk), .miso_i(miso), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi));
  // Compares one value and counts the result.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  // Full sixteen-bit command through the partner.
  task automatic send(input logic [15:0] c);
    mst.xfer(c, 16, rsp);
  endtask : send
  // One high pulse on a modulation input; its falling edge samples the comparator.
  task automatic pulse(input int b);
    @(negedge clk) mod[b] = 1'b1;
    repeat (8) @(negedge clk);
    mod[b] = 1'b0;
    repeat (8) @(negedge clk);
  endtask : pulse
  // Main sequence: reset, table rows, then the awkward cases.
  initial begin
    repeat (16) @(negedge clk);
    check({src, sink}, 16'h0000);
    check({7'h00, mon_sel, slope, cur, mon_en, wd, irq_n}, 16'h0001);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    foreach (rows[i]) begin
      mod = rows[i].mod;
      send(rows[i].cmd);
      check({src, sink}, {rows[i].src, rows[i].sink});
    end
    send(16'h0002);
    check(slope, 1'b1);
    send(16'h0102);
    check({slope, src}, 9'h180);
    send(16'h9E01);
    check({mon_sel, slope, cur, mon_en, wd}, 8'h37);
    mst.xfer(16'h0200, 8, rsp); // A short word must be ignored; taken whole it would clear the watchdog disable bit.
    check({slope, cur, wd}, 3'h3);
    mod = 3'h0;
    send(16'h0152);
    pulse(2);
    check(irq_n, 1'b1);
    comp[2] = 1'b1;
    pulse(2);
    check(irq_n, 1'b0);
    repeat (40) @(negedge clk);
    check(irq_n, 1'b0);
    send(16'h0000);
    check(irq_n, 1'b1);
    comp[2] = 1'b0;
    pulse(2);
    check(irq_n, 1'b0);
    send(16'h0000);
    check(rsp, 16'h0104);
    send(16'h0150);
    comp[2] = 1'b1;
    pulse(2);
    check(irq_n, 1'b1);
    // A reset in mid-run must bring every configured output back to its idle value.
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    check({src, sink}, 16'h0000);
    check({7'h00, mon_sel, slope, cur, mon_en, wd, irq_n}, 16'h0001);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    send(16'h0114);
    check({src, sink}, 16'h0100);
    results();
  end
  // Watchdog against a hang, well beyond the expected run of some 5100 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    results();
  end
endmodule : tb
